// File: common/msc_map.vh
// Register map, field positions and timing constants of the start-up block.
// Contract
// RULE_01: Brake hold time from 4-bit code, 10ms..15s.
// RULE_02: Float hold time from 4-bit code, same table.
// RULE_03: Stationary brake time from 3-bit code, 1..1000ms.
// RULE_04: Coast instead of resync below back-EMF threshold.
// RULE_05: Start method: align, double, probe, slow cycle.
// RULE_06: Alignment voltage ramps at coded rate; Ah undefined.
// RULE_07: Alignment hold time from 4-bit code, 5ms..10s.
// RULE_08: Alignment current limited by coded voltage; 0h reserved.
// RULE_09: Position probe pulse rate from 3-bit code.
// RULE_10: Probe pulse ends at coded current voltage threshold.
// RULE_11: After probe pulse release by brake or tristate.
// RULE_12: First commutation advanced 0/30/60/90 degrees.
// RULE_13: Probe runs 1 to 4 times, results averaged.
// RULE_14: Slow first cycle frequency from code; Ah undefined.
// RULE_15: Speed detection only when its enable is set.
// RULE_16: Timed brake and float only when enabled.
// RULE_17: Brake uses low or high switches per side bit.
// RULE_18: Clock-derived timers; reserved codes flag bad configuration.
// RULE_19: Brake and float finish before start method begins.
`ifndef MSC_MAP_VH
`define MSC_MAP_VH

// Register port addresses.
`define MSC_SPEED_CFG_ADDR 8'h80
`define MSC_START_CFG_ADDR 8'h82
`define MSC_STATUS_ADDR 8'h7e
`define MSC_SPEED_CFG_RESET 32'h00000000
`define MSC_START_CFG_RESET 32'h00000000

// Fields of initial_speed_detect_config.
`define MSC_SPEED_EN_BIT 30
`define MSC_BRAKE_EN_BIT 29
`define MSC_FLOAT_EN_BIT 28
`define MSC_STAT_BRK_EN_BIT 25
`define MSC_BRAKE_SIDE_BIT 21
`define MSC_BRAKE_DUR_LSB 13
`define MSC_FLOAT_DUR_LSB 9
`define MSC_STAT_BRK_DUR_LSB 6
`define MSC_RESYNC_THR_LSB 3

// Fields of motor_startup_config_one.
`define MSC_METHOD_LSB 29
`define MSC_RAMP_LSB 25
`define MSC_ORIENT_DUR_LSB 21
`define MSC_ORIENT_LIM_LSB 17
`define MSC_PROBE_RATE_LSB 14
`define MSC_PROBE_LIM_LSB 10
`define MSC_PROBE_REL_LSB 8
`define MSC_PROBE_ADV_LSB 6
`define MSC_PROBE_REP_LSB 4
`define MSC_FIRST_RATE_LSB 0

// Start methods.
`define MSC_METHOD_ALIGN 2'h0
`define MSC_METHOD_DOUBLE 2'h1
`define MSC_METHOD_PROBE 2'h2
`define MSC_METHOD_SLOW 2'h3

// Timebase: clock rate and the microsecond and millisecond ticks.
`define MSC_CLK_MHZ 200
`define MSC_TICK_US 1
`define MSC_TICK_CYCLES (`MSC_CLK_MHZ * `MSC_TICK_US)
`define MSC_US_PER_MS 1000
`define MSC_SECTORS 6
`define MSC_RISE_MAX 16'hffff

`endif

// File: rtl/msc_timer.v
// Loadable down-counter that counts microsecond ticks.
`timescale 1ns/1ps
module msc_timer #(
  parameter W = 24
) (
  input wire clk,
  input wire rstn,
  input wire tick,
  input wire load,
  input wire [W-1:0] load_val,
  output wire expired
);

  reg [W-1:0] count;

  // Load wins over the tick so a fresh duration never loses its first step.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= {W{1'b0}};
    end else if (load) begin
      count <= load_val;
    end else if (tick && count != {W{1'b0}}) begin
      count <= count - {{(W-1){1'b0}}, 1'b1};
    end
  end

  // Expiry is masked while a load is pending to hide the stale count.
  assign expired = (count == {W{1'b0}}) && !load;

endmodule

// File: rtl/msc_startup.v
// Start-up sequencer: brake, float, stationary brake and start methods.
`timescale 1ns/1ps
`include "msc_map.vh"
module msc_startup #(
  parameter TICK_CYCLES = `MSC_TICK_CYCLES,
  parameter US_PER_MS = `MSC_US_PER_MS
) (
  input wire CLK,
  input wire RSTN,
  input wire CFG_WR,
  input wire CFG_RD,
  input wire [7:0] CFG_ADDR,
  input wire [31:0] CFG_WDATA,
  output reg [31:0] CFG_RDATA,
  input wire START,
  input wire SPEED_DONE,
  input wire SPEED_STILL,
  input wire [11:0] BEMF_MV,
  input wire [11:0] MIN_DUTY_MV,
  input wire [11:0] ISENSE_MV,
  output reg [2:0] HS_ON,
  output reg [2:0] LS_ON,
  output reg [23:0] DRIVE_UV,
  output wire BUSY,
  output reg DONE,
  output reg RESYNC,
  output reg [3:0] FIRST_ANGLE,
  output wire CFG_ERROR
);

  localparam [10:0] S_IDLE = 11'h001;
  localparam [10:0] S_DETECT = 11'h002;
  localparam [10:0] S_STAT_BRK = 11'h004;
  localparam [10:0] S_BRAKE = 11'h008;
  localparam [10:0] S_FLOAT = 11'h010;
  localparam [10:0] S_ALIGN = 11'h020;
  localparam [10:0] S_ALIGN2 = 11'h040;
  localparam [10:0] S_PROBE_ON = 11'h080;
  localparam [10:0] S_PROBE_OFF = 11'h100;
  localparam [10:0] S_SLOW = 11'h200;
  localparam [10:0] S_FINISH = 11'h400;

  reg [31:0] speed_cfg;
  reg [31:0] start_cfg;
  reg [10:0] state;
  reg tmr_load;
  reg [23:0] tmr_val;
  reg rate_load;
  reg [23:0] rate_val;
  reg [7:0] div_cnt;
  reg us_tick;
  reg [9:0] ms_cnt;
  reg ms_tick;
  reg [2:0] sector;
  reg [1:0] run;
  reg [15:0] rise;
  reg [17:0] acc [0:5];
  reg [2:0] best;
  reg [17:0] best_val;
  reg [11:0] resync_thr;
  integer i;
  integer j;
  wire tmr_done;
  wire rate_done;

  // Field views of the two configuration words.
  wire speed_en = speed_cfg[`MSC_SPEED_EN_BIT];
  wire brake_en = speed_cfg[`MSC_BRAKE_EN_BIT];
  wire timed_float_enable = speed_cfg[`MSC_FLOAT_EN_BIT];
  wire stat_brk_en = speed_cfg[`MSC_STAT_BRK_EN_BIT];
  wire brake_switch_side = speed_cfg[`MSC_BRAKE_SIDE_BIT];
  wire [3:0] brake_hold_duration = speed_cfg[`MSC_BRAKE_DUR_LSB +: 4];
  wire [3:0] float_hold_duration = speed_cfg[`MSC_FLOAT_DUR_LSB +: 4];
  wire [2:0] stationary_brake_duration = speed_cfg[`MSC_STAT_BRK_DUR_LSB +: 3];
  wire [2:0] resync_code = speed_cfg[`MSC_RESYNC_THR_LSB +: 3];
  wire [1:0] start_method_select = start_cfg[`MSC_METHOD_LSB +: 2];
  wire [3:0] ramp_code = start_cfg[`MSC_RAMP_LSB +: 4];
  wire [3:0] orient_duration = start_cfg[`MSC_ORIENT_DUR_LSB +: 4];
  wire [3:0] orient_current_limit = start_cfg[`MSC_ORIENT_LIM_LSB +: 4];
  wire [2:0] position_probe_pulse_rate = start_cfg[`MSC_PROBE_RATE_LSB +: 3];
  wire [3:0] position_probe_current_limit = start_cfg[`MSC_PROBE_LIM_LSB +: 4];
  wire [1:0] position_probe_release_select = start_cfg[`MSC_PROBE_REL_LSB +: 2];
  wire [1:0] position_probe_advance = start_cfg[`MSC_PROBE_ADV_LSB +: 2];
  wire [1:0] position_probe_repeat_count = start_cfg[`MSC_PROBE_REP_LSB +: 2];
  wire [3:0] first_cycle_rate = start_cfg[`MSC_FIRST_RATE_LSB +: 4];

  // Hold-time table shared by brake and float, in microseconds.
  function [23:0] hold_us;
    input [3:0] code;
    begin
      case (code)
        4'h0: hold_us = 24'd10000;
        4'h1: hold_us = 24'd50000;
        4'h2: hold_us = 24'd100000;
        4'h3: hold_us = 24'd200000;
        4'h4: hold_us = 24'd300000;
        4'h5: hold_us = 24'd400000;
        4'h6: hold_us = 24'd500000;
        4'h7: hold_us = 24'd750000;
        4'h8: hold_us = 24'd1000000;
        4'h9: hold_us = 24'd2000000;
        4'ha: hold_us = 24'd3000000;
        4'hb: hold_us = 24'd4000000;
        4'hc: hold_us = 24'd5000000;
        4'hd: hold_us = 24'd7500000;
        4'he: hold_us = 24'd10000000;
        default: hold_us = 24'd15000000;
      endcase
    end
  endfunction

  // Stationary brake table in microseconds.
  function [23:0] stat_us;
    input [2:0] code;
    begin
      case (code)
        3'h0: stat_us = 24'd1000;
        3'h1: stat_us = 24'd10000;
        3'h2: stat_us = 24'd25000;
        3'h3: stat_us = 24'd50000;
        3'h4: stat_us = 24'd100000;
        3'h5: stat_us = 24'd250000;
        3'h6: stat_us = 24'd500000;
        default: stat_us = 24'd1000000;
      endcase
    end
  endfunction

  // Alignment hold table in microseconds.
  function [23:0] orient_us;
    input [3:0] code;
    begin
      case (code)
        4'h0: orient_us = 24'd5000;
        4'h1: orient_us = 24'd10000;
        4'h2: orient_us = 24'd25000;
        4'h3: orient_us = 24'd50000;
        4'h4: orient_us = 24'd75000;
        4'h5: orient_us = 24'd100000;
        4'h6: orient_us = 24'd200000;
        4'h7: orient_us = 24'd400000;
        4'h8: orient_us = 24'd600000;
        4'h9: orient_us = 24'd800000;
        4'ha: orient_us = 24'd1000000;
        4'hb: orient_us = 24'd2000000;
        4'hc: orient_us = 24'd4000000;
        4'hd: orient_us = 24'd6000000;
        4'he: orient_us = 24'd8000000;
        default: orient_us = 24'd10000000;
      endcase
    end
  endfunction

  // Ramp step per millisecond in microvolts; the undefined code gives 0.
  function [23:0] ramp_uv;
    input [3:0] code;
    begin
      case (code)
        4'h0: ramp_uv = 24'd100;
        4'h1: ramp_uv = 24'd200;
        4'h2: ramp_uv = 24'd500;
        4'h3: ramp_uv = 24'd1000;
        4'h4: ramp_uv = 24'd2500;
        4'h5: ramp_uv = 24'd5000;
        4'h6: ramp_uv = 24'd7500;
        4'h7: ramp_uv = 24'd10000;
        4'h8: ramp_uv = 24'd25000;
        4'h9: ramp_uv = 24'd50000;
        4'hb: ramp_uv = 24'd100000;
        4'hc: ramp_uv = 24'd250000;
        4'hd: ramp_uv = 24'd500000;
        4'he: ramp_uv = 24'd750000;
        4'hf: ramp_uv = 24'd1000000;
        default: ramp_uv = 24'd0;
      endcase
    end
  endfunction

  // Probe pulse period in microseconds.
  function [23:0] probe_us;
    input [2:0] code;
    begin
      case (code)
        3'h0: probe_us = 24'd20000;
        3'h1: probe_us = 24'd10000;
        3'h2: probe_us = 24'd4000;
        3'h3: probe_us = 24'd2000;
        3'h4: probe_us = 24'd1000;
        3'h5: probe_us = 24'd500;
        3'h6: probe_us = 24'd200;
        default: probe_us = 24'd100;
      endcase
    end
  endfunction

  // One sixth of the first electrical period, in microseconds.
  function [23:0] step_us;
    input [3:0] code;
    begin
      case (code)
        4'h0: step_us = 24'd3333333;
        4'h1: step_us = 24'd1666666;
        4'h2: step_us = 24'd666666;
        4'h3: step_us = 24'd333333;
        4'h4: step_us = 24'd166666;
        4'h5: step_us = 24'd83333;
        4'h6: step_us = 24'd55555;
        4'h7: step_us = 24'd33333;
        4'h8: step_us = 24'd16666;
        4'h9: step_us = 24'd11111;
        4'hb: step_us = 24'd6666;
        4'hc: step_us = 24'd3333;
        4'hd: step_us = 24'd1666;
        4'he: step_us = 24'd1111;
        default: step_us = 24'd833;
      endcase
    end
  endfunction

  // Six-step pattern: high-side phase in [5:3], low-side phase in [2:0].
  function [5:0] step_pat;
    input [2:0] sec;
    begin
      case (sec)
        3'h0: step_pat = 6'b001_010;
        3'h1: step_pat = 6'b001_100;
        3'h2: step_pat = 6'b010_100;
        3'h3: step_pat = 6'b010_001;
        3'h4: step_pat = 6'b100_001;
        default: step_pat = 6'b100_010;
      endcase
    end
  endfunction

  // Reserved and undefined codes block any start. RULE_18 RULE_08 RULE_10
  assign CFG_ERROR = (ramp_code == 4'ha) || (orient_current_limit == 4'h0) ||
                     (position_probe_current_limit < 4'h2) ||
                     position_probe_release_select[1] ||
                     (first_cycle_rate == 4'ha); // RULE_06 RULE_11 RULE_14
  assign BUSY = (state != S_IDLE);

  // Resync threshold in millivolts; code 0 follows the minimum duty level.
  always @* begin
    case (resync_code)
      3'h1: resync_thr = 12'd300;
      3'h2: resync_thr = 12'd400;
      3'h3: resync_thr = 12'd500;
      3'h4: resync_thr = 12'd600;
      3'h5: resync_thr = 12'd800;
      3'h6: resync_thr = 12'd1000;
      3'h7: resync_thr = 12'd1250;
      default: resync_thr = MIN_DUTY_MV;
    endcase
  end

  // Register port with a registered read; unmapped addresses read zero.
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      speed_cfg <= `MSC_SPEED_CFG_RESET;
      start_cfg <= `MSC_START_CFG_RESET;
      CFG_RDATA <= 32'h00000000;
    end else begin
      if (CFG_WR && CFG_ADDR == `MSC_SPEED_CFG_ADDR) begin
        speed_cfg <= CFG_WDATA;
      end
      if (CFG_WR && CFG_ADDR == `MSC_START_CFG_ADDR) begin
        start_cfg <= CFG_WDATA;
      end
      if (CFG_RD) begin
        case (CFG_ADDR)
          `MSC_SPEED_CFG_ADDR: CFG_RDATA <= speed_cfg;
          `MSC_START_CFG_ADDR: CFG_RDATA <= start_cfg;
          `MSC_STATUS_ADDR: CFG_RDATA <= {13'h0000, CFG_ERROR, FIRST_ANGLE,
                                          3'h0, state};
          default: CFG_RDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // Microsecond and millisecond enables from the system clock. RULE_18
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      div_cnt <= 8'h00;
      us_tick <= 1'b0;
      ms_cnt <= 10'h000;
      ms_tick <= 1'b0;
    end else begin
      us_tick <= (div_cnt == TICK_CYCLES - 1);
      div_cnt <= (div_cnt == TICK_CYCLES - 1) ? 8'h00 : div_cnt + 8'h01;
      ms_tick <= us_tick && (ms_cnt == US_PER_MS - 1);
      if (us_tick) begin
        ms_cnt <= (ms_cnt == US_PER_MS - 1) ? 10'h000 : ms_cnt + 10'h001;
      end
    end
  end

  // Duration timer for every timed state.
  msc_timer #(.W(24)) u_dur (
    .clk(CLK),
    .rstn(RSTN),
    .tick(us_tick),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_done)
  );

  // Free-running probe pulse rate timer, reloaded on each expiry. RULE_09
  msc_timer #(.W(24)) u_rate (
    .clk(CLK),
    .rstn(RSTN),
    .tick(us_tick),
    .load(rate_load),
    .load_val(rate_val),
    .expired(rate_done)
  );

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rate_load <= 1'b0;
      rate_val <= 24'h000000;
    end else begin
      rate_load <= rate_done;
      rate_val <= probe_us(position_probe_pulse_rate);
    end
  end

  // Lowest summed rise time marks the rotor; sums rank like averages.
  always @* begin
    best = 3'h0;
    best_val = acc[0];
    for (j = 1; j < `MSC_SECTORS; j = j + 1) begin
      if (acc[j] < best_val) begin
        best = j[2:0];
        best_val = acc[j];
      end
    end
  end

  // Main sequencer.
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= S_IDLE;
      tmr_load <= 1'b0;
      tmr_val <= 24'h000000;
      sector <= 3'h0;
      run <= 2'h0;
      rise <= 16'h0000;
      DRIVE_UV <= 24'h000000;
      DONE <= 1'b0;
      RESYNC <= 1'b0;
      FIRST_ANGLE <= 4'h0;
      for (i = 0; i < `MSC_SECTORS; i = i + 1) begin
        acc[i] <= 18'h00000;
      end
    end else begin
      tmr_load <= 1'b0;
      DONE <= 1'b0;
      RESYNC <= 1'b0;
      // Voltage ramps each millisecond while below the current limit.
      if ((state == S_ALIGN || state == S_ALIGN2 || state == S_SLOW) &&
          ms_tick) begin
        // Limit is code times 100 mV; 1500 mV still fits the 12-bit compare.
        if (ISENSE_MV < {8'h00, orient_current_limit} * 12'd100) begin
          DRIVE_UV <= DRIVE_UV + ramp_uv(ramp_code); // RULE_06 RULE_08
        end
      end
      case (state)
        S_IDLE: begin
          DRIVE_UV <= 24'h000000;
          if (START && !CFG_ERROR) begin
            if (speed_en) begin
              state <= S_DETECT; // RULE_15
            end else if (brake_en) begin
              state <= S_BRAKE; // RULE_16
              tmr_load <= 1'b1;
              tmr_val <= hold_us(brake_hold_duration); // RULE_01
            end else if (timed_float_enable) begin
              state <= S_FLOAT; // RULE_16
              tmr_load <= 1'b1;
              tmr_val <= hold_us(float_hold_duration); // RULE_02
            end else begin
              state <= S_FINISH;
              sector <= 3'h7;
            end
          end
        end
        S_DETECT: begin
          if (SPEED_DONE) begin
            if (SPEED_STILL && stat_brk_en) begin
              state <= S_STAT_BRK;
              tmr_load <= 1'b1;
              tmr_val <= stat_us(stationary_brake_duration); // RULE_03
            end else if (!SPEED_STILL && BEMF_MV >= resync_thr) begin
              RESYNC <= 1'b1; // RULE_04
              state <= S_IDLE;
            end else begin
              state <= S_STAT_BRK; // RULE_04
              tmr_load <= 1'b1;
              tmr_val <= 24'h000000;
            end
          end
        end
        S_STAT_BRK, S_BRAKE: begin
          if (tmr_done) begin
            if (state == S_STAT_BRK && brake_en) begin
              state <= S_BRAKE;
              tmr_load <= 1'b1;
              tmr_val <= hold_us(brake_hold_duration); // RULE_01
            end else if (timed_float_enable) begin
              state <= S_FLOAT;
              tmr_load <= 1'b1;
              tmr_val <= hold_us(float_hold_duration); // RULE_02
            end else begin
              state <= S_FINISH;
              sector <= 3'h7;
            end
          end
        end
        S_FLOAT: begin
          if (tmr_done) begin
            state <= S_FINISH; // RULE_19
            sector <= 3'h7;
          end
        end
        S_ALIGN, S_ALIGN2: begin
          if (tmr_done) begin
            if (state == S_ALIGN &&
                start_method_select == `MSC_METHOD_DOUBLE) begin
              state <= S_ALIGN2;
              sector <= 3'h0;
              tmr_load <= 1'b1;
              tmr_val <= orient_us(orient_duration); // RULE_07
            end else begin
              DONE <= 1'b1;
              FIRST_ANGLE <= {sector, 1'b0};
              state <= S_IDLE;
            end
          end
        end
        S_PROBE_ON: begin
          if (us_tick && rise != `MSC_RISE_MAX) begin
            rise <= rise + 16'h0001;
          end
          if (ISENSE_MV >= {8'h00, position_probe_current_limit} * 12'd100 ||
              rise == `MSC_RISE_MAX) begin
            acc[sector] <= acc[sector] + {2'h0, rise}; // RULE_10 RULE_13
            state <= S_PROBE_OFF;
          end
        end
        S_PROBE_OFF: begin
          if (rate_done) begin
            rise <= 16'h0000;
            if (sector == `MSC_SECTORS - 1) begin
              if (run == position_probe_repeat_count) begin
                DONE <= 1'b1; // RULE_12
                FIRST_ANGLE <= ({best, 1'b0} + {2'h0, position_probe_advance})
                               % 4'd12;
                state <= S_IDLE;
              end else begin
                run <= run + 2'h1; // RULE_13
                sector <= 3'h0;
                state <= S_PROBE_ON;
              end
            end else begin
              sector <= sector + 3'h1;
              state <= S_PROBE_ON; // RULE_09
            end
          end
        end
        S_SLOW: begin
          if (tmr_done) begin
            if (sector == `MSC_SECTORS - 1) begin
              DONE <= 1'b1;
              FIRST_ANGLE <= 4'h0;
              state <= S_IDLE;
            end else begin
              sector <= sector + 3'h1;
              tmr_load <= 1'b1;
              tmr_val <= step_us(first_cycle_rate); // RULE_14
            end
          end
        end
        S_FINISH: begin
          // Dispatch to the start method once pre-drive states are over.
          run <= 2'h0;
          rise <= 16'h0000;
          for (i = 0; i < `MSC_SECTORS; i = i + 1) begin
            acc[i] <= 18'h00000;
          end
          case (start_method_select) // RULE_05 RULE_19
            `MSC_METHOD_PROBE: begin
              sector <= 3'h0;
              state <= S_PROBE_ON;
            end
            `MSC_METHOD_SLOW: begin
              sector <= 3'h0;
              state <= S_SLOW;
              tmr_load <= 1'b1;
              tmr_val <= step_us(first_cycle_rate); // RULE_14
            end
            default: begin
              sector <= (start_method_select == `MSC_METHOD_DOUBLE) ?
                        3'h1 : 3'h0;
              state <= S_ALIGN;
              tmr_load <= 1'b1;
              tmr_val <= orient_us(orient_duration); // RULE_07
            end
          endcase
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Six-step pattern of the current sector, split into its two sides below.
  wire [5:0] pat = step_pat(sector);

  // Switch pattern per state, registered to keep the gates glitch free.
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      HS_ON <= 3'h0;
      LS_ON <= 3'h0;
    end else begin
      case (state)
        S_STAT_BRK, S_BRAKE: begin
          HS_ON <= brake_switch_side ? 3'h7 : 3'h0; // RULE_17
          LS_ON <= brake_switch_side ? 3'h0 : 3'h7; // RULE_17
        end
        S_PROBE_OFF: begin
          // Brake release drains the winding; tristate lets it decay.
          HS_ON <= (!position_probe_release_select[0] && brake_switch_side)
                   ? 3'h7 : 3'h0; // RULE_11
          LS_ON <= (!position_probe_release_select[0] && !brake_switch_side)
                   ? 3'h7 : 3'h0; // RULE_11
        end
        S_ALIGN, S_ALIGN2, S_PROBE_ON, S_SLOW: begin
          HS_ON <= pat[5:3];
          LS_ON <= pat[2:0];
        end
        default: begin
          HS_ON <= 3'h0;
          LS_ON <= 3'h0;
        end
      endcase
    end
  end

endmodule

// File: sim/msc_startup_asserts.sv
// Port checker for the start-up sequencer.
`timescale 1ns/1ps
module msc_startup_asserts (
  input wire CLK,
  input wire RSTN,
  input wire CFG_RD,
  input wire [7:0] CFG_ADDR,
  input wire [31:0] CFG_RDATA,
  input wire START,
  input wire [2:0] HS_ON,
  input wire [2:0] LS_ON,
  input wire BUSY,
  input wire DONE,
  input wire RESYNC,
  input wire [3:0] FIRST_ANGLE,
  input wire CFG_ERROR
);
  // One clock domain; every check sleeps while reset is held.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_brake_one_side: assert property ((&HS_ON) || (&LS_ON) |->
    (HS_ON ^ LS_ON) == 3'h7) else $error("Brake mixes switch sides.");
  a_done_single: assert property (DONE |=> !DONE && !BUSY)
    else $error("Done is not a single closing pulse.");
  a_bad_refused: assert property (!BUSY && START && CFG_ERROR
    |=> !BUSY [*2]) else $error("Start taken with bad configuration.");
  a_start_taken: assert property (!BUSY && START && !CFG_ERROR
    |=> BUSY) else $error("Good start request not taken.");
  a_angle_range: assert property (FIRST_ANGLE < 4'hc)
    else $error("First angle beyond eleven steps.");
  a_angle_hold: assert property (!DONE |-> $stable(FIRST_ANGLE))
    else $error("First angle moved without done.");
  a_resync_idle: assert property (RESYNC |=> !BUSY && !RESYNC)
    else $error("Resync does not return to idle.");
  a_unmapped_zero: assert property (CFG_RD && CFG_ADDR == 8'h84
    |=> CFG_RDATA == 32'h0) else $error("Unmapped read not zero.");
endmodule

// File: sim/msc_winding.sv
// Winding model: sense voltage of the motor phases.
`timescale 1ns/1ps
module msc_winding (
  input wire CLK,
  input wire [2:0] HS_ON,
  input wire [2:0] LS_ON,
  output reg [11:0] ISENSE_MV
);
  // Current builds only across a driven pair; braking on one side and a
  // floating bridge both collapse it at once, which is cruder than copper.
  initial ISENSE_MV = 12'h000;
  always @(negedge CLK) begin
    if ((|HS_ON) && (|LS_ON) && ISENSE_MV < 12'h7d0)
      ISENSE_MV <= ISENSE_MV + 12'h019;
    else if (!((|HS_ON) && (|LS_ON)))
      ISENSE_MV <= 12'h000;
  end
endmodule

// File: sim/tb.sv
// Self-checking bench of the start-up sequencer.
`timescale 1ns/1ps
module tb;
  reg CLK = 0, RSTN = 0, wr_s = 0, rd_s = 0, start = 0, sdone = 0;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg [11:0] bemf = 12'h000;
  reg [5:0] snap;
  reg still = 0;
  reg [31:0] spd [0:6], st [0:6], bad [0:4];
  integer ms [0:6];
  reg [9:0] ex [0:6];
  wire [31:0] rdata;
  wire [23:0] uv;
  wire [11:0] isense;
  wire [3:0] angle;
  wire [2:0] hs, ls;
  wire busy, done, resync, err;
  integer num_errors = 0, checks_done = 0, i, n;
  // Times shrink: 1 us is one clock, so a table entry of 1 ms is 1000
  // clocks; only the ramp's millisecond step is cut to 10 clocks.
  msc_startup #(.TICK_CYCLES(1), .US_PER_MS(10)) i_msc_startup (
    .CLK(CLK), .RSTN(RSTN), .CFG_WR(wr_s), .CFG_RD(rd_s), .CFG_ADDR(addr),
    .CFG_WDATA(wdata), .CFG_RDATA(rdata), .START(start),
    .SPEED_DONE(sdone), .SPEED_STILL(still), .BEMF_MV(bemf),
    .MIN_DUTY_MV(12'h100), .ISENSE_MV(isense), .HS_ON(hs), .LS_ON(ls),
    .DRIVE_UV(uv), .BUSY(busy), .DONE(done), .RESYNC(resync),
    .FIRST_ANGLE(angle), .CFG_ERROR(err));
  msc_winding i_msc_winding (.CLK(CLK), .HS_ON(hs), .LS_ON(ls),
    .ISENSE_MV(isense));
  initial forever #2.5 CLK = ~CLK;
  task wrap_up;
    begin
      $display("Checks %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (s !== e) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  // Bus tasks start and end on a falling edge.
  task wr(input [7:0] a, input [31:0] d);
    begin
      addr = a; wdata = d; wr_s = 1; @(negedge CLK); wr_s = 0;
      @(negedge CLK);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      addr = a; rd_s = 1; @(negedge CLK); rd_s = 0; @(negedge CLK);
      chk(rdata, e);
    end
  endtask
  // Pulses start, counts clocks to done and keeps the switches at clock 20.
  task go;
    begin
      start = 1; @(negedge CLK); start = 0; n = 1;
      while (done !== 1'b1 && n < 30000) begin
        @(negedge CLK); n = n + 1;
        if (n == 20) snap = {hs, ls};
      end
      if (n >= 30000) begin
        num_errors = num_errors + 1; wrap_up;
      end
    end
  endtask
  initial begin
    // Expected column ex holds the first angle over the switches at clock 20.
    spd[0] = 32'h0; st[0] = 32'h001e3c00; ms[0] = 5; ex[0] = 10'h00a;
    spd[1] = 32'h20000000; st[1] = 32'h001e3c00; ms[1] = 15; ex[1] = 10'h007;
    spd[2] = 32'h10000000; st[2] = 32'h003e3c00; ms[2] = 20; ex[2] = 10'h000;
    spd[3] = 32'h0; st[3] = 32'h201e3c00; ms[3] = 10; ex[3] = 10'h00c;
    spd[4] = 32'h0; st[4] = 32'h601e3c0f; ms[4] = 5; ex[4] = 10'h00a;
    spd[5] = 32'h0; st[5] = 32'h401ffd50; ms[5] = 0; ex[5] = 10'h04a;
    spd[6] = 32'h42000000; st[6] = 32'h001e3c00; ms[6] = 6; ex[6] = 10'h007;
    bad[0] = 32'h141e3c00; bad[1] = 32'h001e3e00; bad[2] = 32'h001e0400;
    bad[3] = 32'h00003c00; bad[4] = 32'h001e3c0a;
    repeat (2) @(negedge CLK);
    RSTN = 1;
    chk(err, 1);
    rd(8'h80, 0);
    rd(8'h82, 0);
    rd(8'h84, 0);
    rd(8'h7e, 32'h00040001);
    start = 1; @(negedge CLK); start = 0; @(negedge CLK);
    chk(busy, 0);
    // Detection reports a still motor at once; only the last row listens.
    sdone = 1; still = 1;
    for (i = 0; i < 7; i = i + 1) begin
      wr(8'h80, spd[i]); wr(8'h82, st[i]);
      rd(8'h80, spd[i]);
      rd(8'h82, st[i]);
      go;
      if (ms[i] > 0) chk(n > ms[i]*1000-16 && n < ms[i]*1000+16, 1);
      if (ms[i] > 0) chk(uv > 300 && uv < 900, 1);
      chk(snap, ex[i][5:0]);
      chk(angle, ex[i][9:6]);
      $display("Row %0d finished after %0d clocks", i, n);
    end
    sdone = 0; still = 0;
    // One reserved or undefined code of each field must flag the configuration.
    for (i = 0; i < 5; i = i + 1) begin
      wr(8'h82, bad[i]); @(negedge CLK);
      chk(err, 1);
    end
    $display("Reserved code test finished");
    wr(8'h82, st[0]); wr(8'h80, 32'h20200000); go;
    chk(snap, 6'h38);
    chk(n > 14984 && n < 15016, 1);
    $display("High side brake test finished");
    // Moving motor above the threshold: resync instead of a start.
    wr(8'h80, 32'h40000008); start = 1; @(negedge CLK); start = 0;
    repeat (5) @(negedge CLK);
    chk(busy, 1);
    bemf = 12'h190; sdone = 1; @(negedge CLK); sdone = 0; n = 0;
    while (resync !== 1'b1 && n < 20) begin
      @(negedge CLK); n = n + 1;
    end
    chk(n < 20, 1);
    @(negedge CLK);
    chk(busy, 0);
    $display("Resync test finished");
    wrap_up;
  end
endmodule
bind msc_startup msc_startup_asserts i_chk (.CLK(CLK), .RSTN(RSTN),
  .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR), .CFG_RDATA(CFG_RDATA),
  .START(START), .HS_ON(HS_ON), .LS_ON(LS_ON), .BUSY(BUSY), .DONE(DONE),
  .RESYNC(RESYNC), .FIRST_ANGLE(FIRST_ANGLE), .CFG_ERROR(CFG_ERROR));
